// ### src/wdog_pkg.sv
// Package: timing constants and carrier types for the windowed watchdog supervisor
package wdog_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // Times in microseconds and nanoseconds as printed
   localparam int unsigned EARLY_LIMIT_US = 1500;
   localparam int unsigned LATE_LIMIT_US = 15000;
   localparam int unsigned FAULT_PULSE_US = 1000;
   localparam int unsigned RESET_HOLD_US = 180000;
   localparam int unsigned MR_MIN_NS = 1000;
   localparam int unsigned KICK_MIN_NS = 300;
   localparam longint unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned EARLY_LIMIT_CYC = int'(longint'(EARLY_LIMIT_US) * CYC_PER_US);
   localparam int unsigned LATE_LIMIT_CYC = int'(longint'(LATE_LIMIT_US) * CYC_PER_US);
   localparam int unsigned FAULT_PULSE_CYC = int'(longint'(FAULT_PULSE_US) * CYC_PER_US);
   localparam int unsigned RESET_HOLD_CYC = int'(longint'(RESET_HOLD_US) * CYC_PER_US);
   // Least times round up
   localparam int unsigned MR_FILT_CYC = (MR_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned KICK_FILT_CYC = (KICK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 24;
   localparam int FILT_W = 8;

   typedef struct packed {
      logic kick_input;
      logic manual_reset_in_n;
      logic undervoltage;
   } sup_in_t;

   typedef struct packed {
      logic reset_out_n;
      logic fault_pulse_out_oe_n;
      logic fault_pulse_out;
   } sup_out_t;
endpackage

// ### src/pin_filter.sv
// Two-flop synchroniser followed by a minimum-width glitch filter
`timescale 1ns/1ps
module pin_filter #(
   parameter int unsigned MIN_CYC = 12,
   parameter int FILT_W = 8,
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic meta_q;
   logic sync_q;
   logic [FILT_W-1:0] cnt_q;

   initial begin
      if (MIN_CYC < 1 || MIN_CYC >= (1 << FILT_W)) begin
         $error("pin_filter: MIN_CYC out of range");
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end

   // New level accepted only after it stands MIN_CYC cycles
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         level <= RESET_VAL;
      end else if (sync_q == level) begin
         cnt_q <= '0;
      end else if (cnt_q >= FILT_W'(MIN_CYC - 1)) begin
         cnt_q <= '0;
         level <= sync_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule

// ### src/windowed_watchdog_supervisor.sv
// Windowed watchdog with reset supervisor, manual reset and fault pulse output
//
// Behaviour
// - Kick falling edge before early limit expires emits a fault pulse.
// - No kick falling edge before late limit expires emits a fault pulse.
// - Kick falling edge inside the window produces no fault; operation continues.
// - Fault pulse drives the output low for about 1 ms.
// - Timer clears on in-window kick, and when reset or fault pulse deasserts.
// - Kick activity is ignored while reset or fault pulse is asserted.
// - First kick after reset or fault release is not checked against early limit.
// - Fault pulse can only occur while reset is released.
// - Fault pulse is independent; a watchdog fault never asserts reset.
// - Manual reset low asserts reset, zeroes timer, releases fault output.
// - Reset held at least 180 ms after manual reset returns high.
// - Reset held during undervoltage and for the timeout after it clears.
`timescale 1ns/1ps
module windowed_watchdog_supervisor
   import wdog_pkg::*;
#(
   parameter int unsigned EARLY_CYC = wdog_pkg::EARLY_LIMIT_CYC,
   parameter int unsigned LATE_CYC = wdog_pkg::LATE_LIMIT_CYC,
   parameter int unsigned PULSE_CYC = wdog_pkg::FAULT_PULSE_CYC,
   parameter int unsigned HOLD_CYC = wdog_pkg::RESET_HOLD_CYC,
   parameter int unsigned MR_MIN_CYC = wdog_pkg::MR_FILT_CYC,
   parameter int unsigned KICK_MIN_CYC = wdog_pkg::KICK_FILT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire wdog_pkg::sup_in_t pins_in,
   output wdog_pkg::sup_out_t pins_out
);
   import wdog_pkg::*;

   typedef enum logic [1:0] {
      WD_IDLE,
      WD_FIRST,
      WD_ARMED,
      WD_FAULT
   } wd_state_t;

   logic kick_lvl;
   logic mr_lvl;
   logic uv_meta_q;
   logic uv_q;
   logic kick_prev_q;
   logic kick_fall;
   logic reset_out_n_q;
   logic [CNT_W-1:0] hold_q;
   logic [CNT_W-1:0] timer_q;
   logic [CNT_W-1:0] pulse_q;
   wd_state_t state_q;
   logic fault_q;
   logic reset_hold_req;
   logic wd_off;
   logic early_hit;
   logic late_hit;
   logic pulse_end;
   logic fault_start;

   // Terminal count test shared by every timing counter
   function automatic logic count_done(input logic [CNT_W-1:0] cnt, input int unsigned lim);
      count_done = (cnt >= CNT_W'(lim - 1));
   endfunction

   // Each count must fit its counter; zero would underflow the terminal test
   initial begin
      if (EARLY_CYC < 1) begin
         $error("windowed_watchdog_supervisor: early limit must be at least one cycle");
      end
      if (EARLY_CYC >= LATE_CYC) begin
         $error("windowed_watchdog_supervisor: early limit must be below late limit");
      end
      if (LATE_CYC >= (1 << CNT_W)) begin
         $error("windowed_watchdog_supervisor: late limit does not fit counter width");
      end
      if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin
         $error("windowed_watchdog_supervisor: fault pulse width out of range");
      end
      if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CNT_W)) begin
         $error("windowed_watchdog_supervisor: reset hold time out of range");
      end
      if (MR_MIN_CYC < 1 || MR_MIN_CYC >= (1 << FILT_W)) begin
         $error("windowed_watchdog_supervisor: manual reset filter width out of range");
      end
      if (KICK_MIN_CYC < 1 || KICK_MIN_CYC >= (1 << FILT_W)) begin
         $error("windowed_watchdog_supervisor: kick filter width out of range");
      end
   end

   // Short manual reset pulses are rejected by the filter
   pin_filter #(.MIN_CYC(KICK_MIN_CYC), .FILT_W(FILT_W), .RESET_VAL(1'b1)) u_kick (
      .clk(clk),
      .rst_n(rst_n),
      .pin(pins_in.kick_input),
      .level(kick_lvl)
   );
   pin_filter #(.MIN_CYC(MR_MIN_CYC), .FILT_W(FILT_W), .RESET_VAL(1'b0)) u_mr (
      .clk(clk),
      .rst_n(rst_n),
      .pin(pins_in.manual_reset_in_n),
      .level(mr_lvl)
   );

   // Undervoltage comes from the analog domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         uv_meta_q <= 1'b1;
         uv_q <= 1'b1;
      end else begin
         uv_meta_q <= pins_in.undervoltage;
         uv_q <= uv_meta_q;
      end
   end

   assign reset_hold_req = !mr_lvl || uv_q;

   // Reset timeout counter; only manual reset and undervoltage feed it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hold_q <= '0;
      end else if (reset_hold_req || reset_out_n_q) begin
         hold_q <= '0;
      end else if (!count_done(hold_q, HOLD_CYC)) begin
         hold_q <= hold_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reset_out_n_q <= 1'b0;
      end else if (reset_hold_req) begin
         reset_out_n_q <= 1'b0;
      end else if (count_done(hold_q, HOLD_CYC)) begin
         reset_out_n_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         kick_prev_q <= 1'b1;
      end else begin
         kick_prev_q <= kick_lvl;
      end
   end

   assign kick_fall = kick_prev_q && !kick_lvl;

   // Watchdog stops as soon as reset is requested, so a fault never overlaps reset
   assign wd_off = !reset_out_n_q || reset_hold_req;

   // Edge and late limit in one cycle: the edge wins
   assign early_hit = (state_q == WD_ARMED) && kick_fall && (timer_q < CNT_W'(EARLY_CYC));
   assign late_hit = (state_q == WD_FIRST || state_q == WD_ARMED) && !kick_fall &&
      count_done(timer_q, LATE_CYC);
   assign pulse_end = (state_q == WD_FAULT) && count_done(pulse_q, PULSE_CYC);
   assign fault_start = !wd_off && (early_hit || late_hit);

   // Watchdog window state machine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= WD_IDLE;
      end else if (wd_off) begin
         state_q <= WD_IDLE;
      end else begin
         unique case (state_q)
            WD_IDLE: begin
               // Reset just released: restart timing
               state_q <= WD_FIRST;
            end
            WD_FIRST: begin
               // Early check skipped to avoid a false fast fault
               if (kick_fall) begin
                  state_q <= WD_ARMED;
               end else if (late_hit) begin
                  state_q <= WD_FAULT;
               end
            end
            WD_ARMED: begin
               if (early_hit || late_hit) begin
                  state_q <= WD_FAULT;
               end
            end
            WD_FAULT: begin
               // Kick edges have no effect here
               if (pulse_end) begin
                  state_q <= WD_FIRST;
               end
            end
         endcase
      end
   end

   // Timer only runs while a window is open
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_q <= '0;
      end else if (wd_off || state_q == WD_IDLE || state_q == WD_FAULT) begin
         timer_q <= '0;
      end else if (kick_fall || late_hit) begin
         timer_q <= '0;
      end else begin
         timer_q <= timer_q + 1'b1;
      end
   end

   // Pulse width counter, held at zero outside a fault
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_q <= '0;
      end else if (wd_off || state_q != WD_FAULT) begin
         pulse_q <= '0;
      end else if (!pulse_end) begin
         pulse_q <= pulse_q + 1'b1;
      end
   end

   // Reset request clears the fault in the same edge that asserts reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
      end else if (wd_off) begin
         fault_q <= 1'b0;
      end else if (fault_start) begin
         fault_q <= 1'b1;
      end else if (pulse_end) begin
         fault_q <= 1'b0;
      end
   end

   // Open-drain fault output: enable low while pulling low
   always_comb begin
      pins_out.reset_out_n = reset_out_n_q;
      pins_out.fault_pulse_out = 1'b0;
      pins_out.fault_pulse_out_oe_n = !fault_q;
   end
endmodule

// ### test/wdog_chk.sv
// Port checker for the windowed watchdog supervisor
`timescale 1ns/1ps
module wdog_chk
   import wdog_pkg::*;
#(
   parameter int unsigned LATE_CYC = 100,
   parameter int unsigned PULSE_CYC = 10,
   parameter int unsigned HOLD_CYC = 50
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire wdog_pkg::sup_in_t pins_in,
   input wire wdog_pkg::sup_out_t pins_out
);
   logic ok;
   logic fo;
   int unsigned low_q;
   int unsigned up_q;
   int unsigned quiet_q;
   assign ok = pins_out.reset_out_n;
   assign fo = pins_out.fault_pulse_out_oe_n;
   // Quiet count restarts on a kick pin fall or while reset or fault is asserted, so it only bounds from above
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_q <= 0;
         up_q <= 0;
         quiet_q <= 0;
      end else begin
         low_q <= fo ? 0 : low_q + 1;
         up_q <= (pins_in.manual_reset_in_n && !pins_in.undervoltage) ? up_q + 1 : 0;
         quiet_q <= (ok && fo && !$fell(pins_in.kick_input)) ? quiet_q + 1 : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_pulse_len; $rose(fo) && ok |-> low_q == PULSE_CYC; endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("fault pulse width wrong");
   property p_fault_up; !fo |-> ok; endproperty
   a_fault_up: assert property (p_fault_up) else $error("fault while reset asserted");
   property p_indep; (pins_in.manual_reset_in_n && !pins_in.undervoltage)[*8] ##0 ok |=> ok; endproperty
   a_indep: assert property (p_indep) else $error("reset asserted without cause");
   property p_mr_low; (!pins_in.manual_reset_in_n)[*8] |=> !ok && fo; endproperty
   a_mr_low: assert property (p_mr_low) else $error("manual reset not honoured");
   property p_hold; $rose(ok) |-> up_q >= HOLD_CYC; endproperty
   a_hold: assert property (p_hold) else $error("reset released too soon");
   property p_uv; pins_in.undervoltage[*4] |=> !ok; endproperty
   a_uv: assert property (p_uv) else $error("undervoltage did not assert reset");
   property p_late; quiet_q <= LATE_CYC + 8; endproperty
   a_late: assert property (p_late) else $error("late fault missing");
   property p_first; $rose(fo) |-> fo[*4]; endproperty
   a_first: assert property (p_first) else $error("fault right after release");
endmodule

bind windowed_watchdog_supervisor wdog_chk #(.LATE_CYC(LATE_CYC), .PULSE_CYC(PULSE_CYC), .HOLD_CYC(HOLD_CYC)) chk (
   .clk(clk), .rst_n(rst_n), .pins_in(pins_in), .pins_out(pins_out));

// ### test/host_model.sv
// Host processor model toggling the kick pin
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   input wire logic reset_out_n,
   input wire logic en,
   input wire logic [7:0] half,
   output logic kick
);
   logic [7:0] cnt_q;
   // Host in reset leaves its port high
   always_ff @(posedge clk) begin
      if (!en || !reset_out_n) begin
         kick <= 1'b1;
         cnt_q <= 8'h00;
      end else if (cnt_q >= half - 8'h01) begin
         kick <= ~kick;
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// ### test/testbench.sv
// Self-checking bench for the windowed watchdog supervisor
`timescale 1ns/1ps
module testbench;
   import wdog_pkg::*;
   localparam int L = 100;
   localparam int P = 10;
   localparam int H = 50;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mr_n = 1'b1;
   logic uv = 1'b0;
   logic en = 1'b0;
   logic [7:0] half = 8'h14;
   logic kick;
   sup_in_t pins_in;
   sup_out_t pins_out;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   assign pins_in = {kick, mr_n, uv};
   // Short counts keep the run small
   windowed_watchdog_supervisor #(.EARLY_CYC(20), .LATE_CYC(L), .PULSE_CYC(P), .HOLD_CYC(H), .MR_MIN_CYC(4),
      .KICK_MIN_CYC(2)) dut (.clk(clk), .rst_n(rst_n), .pins_in(pins_in), .pins_out(pins_out));
   host_model host (.clk(clk), .reset_out_n(pins_out.reset_out_n), .en(en), .half(half), .kick(kick));
   initial forever #12.5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Cycles until reset (sel) or fault enable reaches lvl, capped at max
   task automatic wait_for(input bit sel, input logic lvl, input int max, output int k);
      k = 0;
      while ((sel ? pins_out.reset_out_n : pins_out.fault_pulse_out_oe_n) !== lvl && k < max) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic t_late();
      wait_for(1'b0, 1'b0, L + 20, n);
      check(n >= L - 2 && n <= L + 4, 1);
      wait_for(1'b0, 1'b1, 50, n);
      check(n, P);
      check(pins_out.fault_pulse_out, 1'b0);
      check(pins_out.reset_out_n, 1'b1);
   endtask
   task automatic t_window();
      @(posedge clk);
      en <= 1'b1;
      wait_for(1'b0, 1'b0, 400, n);
      check(n, 400);
   endtask
   task automatic t_early_mr();
      @(posedge clk);
      half <= 8'h04;
      wait_for(1'b0, 1'b0, 40, n);
      check(n < 40, 1);
      @(posedge clk);
      mr_n <= 1'b0;
      repeat (12) @(posedge clk);
      check(pins_out.reset_out_n, 1'b0);
      check(pins_out.fault_pulse_out_oe_n, 1'b1);
      mr_n <= 1'b1;
      en <= 1'b0;
      wait_for(1'b1, 1'b1, 200, n);
      check(n >= H, 1);
   endtask
   task automatic t_glitch_uv();
      @(posedge clk);
      mr_n <= 1'b0;
      @(posedge clk);
      mr_n <= 1'b1;
      repeat (12) @(posedge clk);
      check(pins_out.reset_out_n, 1'b1);
      uv <= 1'b1;
      repeat (20) @(posedge clk);
      check(pins_out.reset_out_n, 1'b0);
      // First kick after release lands before the early limit
      half <= 8'h0c;
      en <= 1'b1;
      uv <= 1'b0;
      wait_for(1'b1, 1'b1, 200, n);
      check(n >= H && n <= H + 8, 1);
      wait_for(1'b0, 1'b0, 200, n);
      check(n, 200);
   endtask
   // Hang guard well beyond the roughly one thousand cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wait_for(1'b1, 1'b1, 200, n);
      check(n >= H && n <= H + 12, 1);
      t_late();
      t_window();
      t_early_mr();
      t_glitch_uv();
      results();
   end
endmodule
